// >>> rtl/adc_serial_port.sv
`timescale 1ns/100ps
`default_nettype none

module adc_serial_port (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Serial link pins from the host.
    input wire adc_pkg::link_in_s link_i,
    // Serial data out, with an active-low output enable.
    output logic sdo_o,
    output logic sdo_oe_n_o,
    // Conversion engine handshake.
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic signed [24:0] conv_value_i,
    // Input multiplexer selection.
    output adc_pkg::chan_addr_s conv_addr_o,
    output adc_pkg::mux_sel_s mux_sel_o,
    // Status.
    output logic converting_o
);
    import adc_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------

    // Three stages per pin; the first stage only feeds the second.
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] pin_r;
    logic [2:0] pin_prev_r;

    genvar b;
    generate
        for (b = 0; b < 3; b++) begin : g_sync
            // A change counts only once the second and third stages agree.
            always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    sync1_r[b] <= 1'h1;
                    sync2_r[b] <= 1'h1;
                    sync3_r[b] <= 1'h1;
                    pin_r[b] <= 1'h1;
                end else begin
                    sync1_r[b] <= link_i[b];
                    sync2_r[b] <= sync1_r[b];
                    sync3_r[b] <= sync2_r[b];
                    if (sync2_r[b] == sync3_r[b]) begin
                        pin_r[b] <= sync3_r[b];
                    end
                end
            end
        end
    endgenerate

    // Previous filtered level, for edge detection.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_prev_r <= 3'h7;
        end else begin
            pin_prev_r <= pin_r;
        end
    end

    link_in_s pins;
    link_in_s pins_prev;
    logic selected;
    logic sck_rise;
    logic sck_fall;

    assign pins = pin_r;
    assign pins_prev = pin_prev_r;
    assign selected = !pins.cs_n;
    // Clock edges count only while chip select is low.
    assign sck_rise = selected && pins.sck && !pins_prev.sck;
    assign sck_fall = selected && !pins.sck && pins_prev.sck;

    // ------------------------------------------------------------------
    // Conversion state.
    // ------------------------------------------------------------------

    conv_state_e state_r;
    logic start_r;
    logic read_end;
    logic [5:0] fall_cnt_r;
    logic [5:0] rise_cnt_r;
    chan_addr_s cur_addr_r;
    chan_addr_s next_addr_r;

    // The 32nd falling edge of a read closes it and starts the next conversion.
    assign read_end = sck_fall && (state_r == ST_READY) && (fall_cnt_r == LAST_FALL);

    // Reset enters conversion at once, so the first result needs no read.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= ST_CONVERT;
        end else begin
            case (state_r)
                ST_CONVERT: begin
                    if (conv_done_i) begin
                        state_r <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (read_end) begin
                        state_r <= ST_CONVERT;
                    end
                end
                default: begin
                    state_r <= ST_CONVERT;
                end
            endcase
        end
    end

    // One-cycle start pulse, also issued straight after reset.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_r <= 1'h1;
        end else begin
            start_r <= read_end;
        end
    end

    assign conv_start_o = start_r;
    assign converting_o = (state_r == ST_CONVERT);

    // ------------------------------------------------------------------
    // Channel address: pending and in use.
    // ------------------------------------------------------------------

    logic [7:0] rx_r;
    logic [7:0] rx_word;

    // The 8-bit host word arrives on the first eight rising edges.
    assign rx_word = {rx_r[6:0], pins.sdi};

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_r <= 8'h00;
        end else if (sck_rise && state_r == ST_READY && rise_cnt_r < RX_LAST_RISE) begin
            rx_r <= rx_word;
        end
    end

    // Rising edges of the current read; cleared when chip select rises.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rise_cnt_r <= CNT_ZERO;
        end else if (!selected || read_end) begin
            rise_cnt_r <= CNT_ZERO;
        end else if (sck_rise && state_r == ST_READY && rise_cnt_r != LAST_FALL + 6'h01) begin
            rise_cnt_r <= rise_cnt_r + 6'h01;
        end
    end

    // Only pattern 101 loads; 100, 000 and anything else keep the old one.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            next_addr_r <= ADDR_RESET;
        end else if (sck_rise && state_r == ST_READY
                     && rise_cnt_r == RX_LAST_RISE - 6'h01
                     && rx_word[7:5] == CTRL_UPDATE) begin
            next_addr_r <= rx_word[4:0];
        end
    end

    // The pending address takes effect only as the next conversion begins.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cur_addr_r <= ADDR_RESET;
        end else if (read_end) begin
            cur_addr_r <= next_addr_r;
        end
    end

    assign conv_addr_o = cur_addr_r;

    // Registered decode for the input multiplexer.
    chan_select_decoder u_decoder (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .addr_i(cur_addr_r),
        .mux_sel_o(mux_sel_o)
    );

    // ------------------------------------------------------------------
    // Result word assembly.
    // ------------------------------------------------------------------

    logic sign_bit;
    logic [22:0] result_field;
    logic [31:0] word_nxt;
    logic [31:0] word_r;

    // Clamp beyond full scale; in range, the field is the low 23 bits.
    always_comb begin
        if (conv_value_i >= FS_POS) begin
            sign_bit = 1'h1;
            result_field = OVER_CODE;
        end else if (conv_value_i < FS_NEG) begin
            sign_bit = 1'h0;
            result_field = UNDER_CODE;
        end else begin
            // Zero is counted as positive, so it reads with the sign high.
            sign_bit = !conv_value_i[VALUE_BITS - 1];
            result_field = conv_value_i[RESULT_BITS - 1:0];
        end
    end

    // Done flag low, filler low, then sign, result, tag and even parity.
    always_comb begin
        word_nxt = '0;
        word_nxt[POS_DONE] = 1'h0;
        word_nxt[POS_FILLER] = FILLER_VALUE;
        word_nxt[POS_SIGN] = sign_bit;
        word_nxt[POS_RESULT_MSB:POS_RESULT_LSB] = result_field;
        word_nxt[POS_TAG_MSB:POS_TAG_LSB] = cur_addr_r;
        word_nxt[POS_PARITY] = ^word_nxt[WORD_BITS - 1:1];
    end

    // The word is captured once per conversion and kept for re-reads.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            word_r <= WORD_RESET;
        end else if (conv_done_i && state_r == ST_CONVERT) begin
            word_r <= word_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output shift register.
    // ------------------------------------------------------------------

    logic [31:0] shift_r;

    // Shifts on falling edges only; a read cut short restarts from bit 31.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shift_r <= WORD_RESET;
        end else if (conv_done_i && state_r == ST_CONVERT) begin
            shift_r <= word_nxt;
        end else if (!selected) begin
            shift_r <= word_r;
        end else if (sck_fall && state_r == ST_READY) begin
            shift_r <= {shift_r[WORD_BITS - 2:0], 1'h0};
        end
    end

    // Falling edges of the current read; the 31st puts parity out.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fall_cnt_r <= CNT_ZERO;
        end else if (!selected || read_end) begin
            fall_cnt_r <= CNT_ZERO;
        end else if (sck_fall && state_r == ST_READY) begin
            fall_cnt_r <= fall_cnt_r + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Serial output pin.
    // ------------------------------------------------------------------

    // During conversion the pin shows a high done flag; it falls in the
    // cycle after completion, which lets the host use it as an interrupt.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sdo_o <= 1'h1;
        end else if (read_end) begin
            sdo_o <= 1'h1;
        end else if (state_r == ST_CONVERT) begin
            // Done drops the flag at once; a stray done while reading is ignored.
            sdo_o <= !conv_done_i;
        end else begin
            sdo_o <= shift_r[WORD_BITS - 1];
        end
    end

    // The pin floats while chip select is high; low enable means driving.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sdo_oe_n_o <= 1'h1;
        end else begin
            sdo_oe_n_o <= !selected;
        end
    end

endmodule

`default_nettype wire

// >>> include/adc_pkg.sv
`default_nettype none

package adc_pkg;

    // ------------------------------------------------------------------
    // Word layout of the serial result.
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 32;
    localparam int RESULT_BITS = 23;
    localparam int ADDR_BITS = 5;
    localparam int CTRL_BITS = 3;
    localparam int RX_BITS = 8;
    localparam int NUM_CHANNELS = 16;
    localparam int PAIR_COUNT = 8;
    localparam int VALUE_BITS = 25;
    localparam int SYNC_STAGES = 3;

    // Bit positions inside the 32-bit word.
    localparam int POS_DONE = 31;
    localparam int POS_FILLER = 30;
    localparam int POS_SIGN = 29;
    localparam int POS_RESULT_MSB = 28;
    localparam int POS_RESULT_LSB = 6;
    localparam int POS_TAG_MSB = 5;
    localparam int POS_TAG_LSB = 1;
    localparam int POS_PARITY = 0;

    // Edge counts and codes.
    localparam logic [5:0] LAST_FALL = 6'h1F;
    localparam logic [5:0] RX_LAST_RISE = 6'h08;
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [2:0] CTRL_UPDATE = 3'h5;
    localparam logic FILLER_VALUE = 1'h0;

    // Clamp codes of the result field and full-scale thresholds of the value.
    localparam logic [22:0] OVER_CODE = 23'h400000;
    localparam logic [22:0] UNDER_CODE = 23'h3FFFFF;
    localparam logic signed [24:0] FS_POS = 25'sh0400000;
    localparam logic signed [24:0] FS_NEG = -25'sh0400000;

    // Reset values.
    localparam logic [31:0] WORD_RESET = 32'h80000000;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic single_ended_select;
        logic polarity;
        logic [2:0] pair_index;
    } chan_addr_s;

    localparam chan_addr_s ADDR_RESET = 5'h00;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
    } link_in_s;

    typedef struct packed {
        logic [15:0] pos_sel;
        logic [15:0] neg_sel;
        logic neg_common;
    } mux_sel_s;

    typedef enum logic {
        ST_CONVERT,
        ST_READY
    } conv_state_e;

endpackage

`default_nettype wire

// >>> rtl/chan_select_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module chan_select_decoder (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Address in, registered selection out.
    input wire adc_pkg::chan_addr_s addr_i,
    output adc_pkg::mux_sel_s mux_sel_o
);
    import adc_pkg::*;

    mux_sel_s sel_nxt;

    // ------------------------------------------------------------------
    // One decode term per channel: even channels 2n, odd ones 2n+1.
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            localparam logic [2:0] PAIR = 3'(ch / 2);
            localparam logic ODD = 1'(ch % 2);
            logic hit;
            assign hit = (addr_i.pair_index == PAIR);
            // Differential: even is positive unless polarity swaps the pair.
            // Single ended: the polarity bit picks the even or odd channel.
            assign sel_nxt.pos_sel[ch] = hit && (addr_i.polarity == ODD);
            assign sel_nxt.neg_sel[ch] = hit && !addr_i.single_ended_select
                                         && (addr_i.polarity != ODD);
        end
    endgenerate

    // The common input is the negative side only in single-ended mode.
    assign sel_nxt.neg_common = addr_i.single_ended_select;

    // Registered so that the analog switches never see decode glitches.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mux_sel_o <= '{pos_sel: 16'h0001, neg_sel: 16'h0002, neg_common: 1'h0};
        end else begin
            mux_sel_o <= sel_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> verif/adc_serial_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module adc_serial_port_assertions (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Watched ports.
    input wire adc_pkg::link_in_s link_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_n_o,
    input wire logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic converting_o,
    input wire adc_pkg::chan_addr_s conv_addr_o,
    input wire adc_pkg::mux_sel_s mux_sel_o
);
    import adc_pkg::*;

    // One clock domain; reset abandons every attempt in flight.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_oe_off;
        link_i.cs_n [*8] |-> sdo_oe_n_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");

    property p_no_start_deselected;
        link_i.cs_n [*8] |-> !conv_start_o;
    endproperty
    a_no_start_deselected: assert property (p_no_start_deselected) else $error("start while deselected");

    property p_start_pulse;
        conv_start_o |=> !conv_start_o ##0 converting_o && sdo_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");

    property p_idle_holds;
        !converting_o ##1 converting_o |-> conv_start_o;
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("conversion without start");

    property p_busy_flag;
        converting_o && $past(converting_o) |-> sdo_o;
    endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("busy flag low");

    property p_done_flag;
        converting_o && conv_done_i |=> !converting_o && !sdo_o;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag late");

    property p_addr_at_start;
        $changed(conv_addr_o) |-> conv_start_o || $past(conv_start_o);
    endproperty
    a_addr_at_start: assert property (p_addr_at_start) else $error("address moved mid-run");

    property p_pos_decode;
        $stable(conv_addr_o) |-> mux_sel_o.neg_common == conv_addr_o.single_ended_select
            && mux_sel_o.pos_sel == 16'h0001 << {conv_addr_o.pair_index, conv_addr_o.polarity};
    endproperty
    a_pos_decode: assert property (p_pos_decode) else $error("positive select wrong");

    property p_neg_decode;
        $stable(conv_addr_o) |-> mux_sel_o.neg_sel == (conv_addr_o.single_ended_select ? 16'h0000
            : 16'h0001 << {conv_addr_o.pair_index, !conv_addr_o.polarity});
    endproperty
    a_neg_decode: assert property (p_neg_decode) else $error("negative select wrong");
endmodule

bind adc_serial_port adc_serial_port_assertions i_chk (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .link_i(link_i),
    .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o),
    .conv_start_o(conv_start_o),
    .conv_done_i(conv_done_i),
    .converting_o(converting_o),
    .conv_addr_o(conv_addr_o),
    .mux_sel_o(mux_sel_o)
);

`default_nettype wire

// >>> verif/adc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module adc_host_model (
    // Clock that paces the host's bit timing.
    input wire logic sys_clk_i,
    // Serial data from the device.
    input wire logic sdo_i,
    // Link pins to the device.
    output adc_pkg::link_in_s link_o
);
    import adc_pkg::*;

    // Deselected with the serial clock parked high.
    initial link_o = 3'h6;

    // Waits whole system clocks.
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // Moves chip select on its own.
    task automatic cs_set(input logic v);
        @(posedge sys_clk_i);
        link_o.cs_n <= v;
    endtask

    // Clock pulses with chip select high, which the device must ignore.
    task automatic idle_clocks(input int n);
        repeat (n) begin
            wait_clk(4);
            link_o.sck <= 1'b0;
            wait_clk(4);
            link_o.sck <= 1'b1;
        end
    endtask

    // One read of nbits clocks; bits are taken late in the high phase,
    // since the device answers a falling edge only after its synchroniser.
    task automatic frame(input logic [7:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h0;
        cs_set(1'b0);
        wait_clk(8);
        for (int k = 0; k < nbits; k++) begin
            @(negedge sys_clk_i);
            rx = {rx[30:0], sdo_i};
            @(posedge sys_clk_i);
            link_o.sck <= 1'b0;
            link_o.sdi <= (k < 8) ? tx[7 - k] : ~link_o.sdi;
            wait_clk(4);
            link_o.sck <= 1'b1;
            wait_clk(3);
        end
        wait_clk(8);
        link_o.cs_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

// >>> verif/adc_serial_port_bench.sv
`timescale 1ns/100ps
`default_nettype none

module adc_serial_port_bench;
    import adc_pkg::*;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    link_in_s link;
    logic sdo;
    logic sdo_oe_n;
    logic sdo_line;
    logic conv_start;
    logic converting;
    logic conv_done = 1'b0;
    logic signed [24:0] conv_value = 25'h0000000;
    chan_addr_s conv_addr;
    mux_sel_s mux_sel;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_start = 0;
    logic [31:0] w;
    logic [31:0] exp;
    logic [2:0] ctl;
    logic [4:0] ad;
    logic [4:0] cur;
    logic signed [24:0] vals [8] = '{25'sh0000000, -25'sh0000001, 25'sh0400000, 25'sh03FFFFF,
        -25'sh0400000, -25'sh0400001, 25'sh0FFFFFF, 25'sh0200000};
    logic [2:0] bad [4] = '{3'h4, 3'h0, 3'h6, 3'h3};

    // 40 MHz system clock.
    always #12.5 sys_clk = ~sys_clk;

    // A released data line shows the inverse of its last bit, never a stale level.
    assign sdo_line = sdo_oe_n ? ~sdo : sdo;

    adc_serial_port i_adc_serial_port (
        .sys_clk_i(sys_clk),
        .sys_rst_i(sys_rst),
        .link_i(link),
        .sdo_o(sdo),
        .sdo_oe_n_o(sdo_oe_n),
        .conv_start_o(conv_start),
        .conv_done_i(conv_done),
        .conv_value_i(conv_value),
        .conv_addr_o(conv_addr),
        .mux_sel_o(mux_sel),
        .converting_o(converting)
    );

    adc_host_model i_adc_host_model (
        .sys_clk_i(sys_clk),
        .sdo_i(sdo_line),
        .link_o(link)
    );

    // Expected word: clamped result, channel tag and even parity.
    function automatic logic [31:0] exp_word(input logic signed [24:0] v, input logic [4:0] tag);
        logic s;
        logic [22:0] f;
        logic [31:0] r;
        if (v >= 25'sh0400000) begin
            s = 1'b1;
            f = 23'h400000;
        end else if (v < -25'sh0400000) begin
            s = 1'b0;
            f = 23'h3FFFFF;
        end else begin
            s = !v[24];
            f = v[22:0];
        end
        r = {2'h0, s, f, tag, 1'b0};
        r[0] = ^r[31:1];
        return r;
    endfunction

    // Expected selection: the positive input is always channel 2n+polarity.
    function automatic mux_sel_s exp_mux(input logic [4:0] a);
        mux_sel_s m;
        m.pos_sel = 16'h0001 << {a[2:0], a[3]};
        m.neg_sel = a[4] ? 16'h0000 : 16'h0001 << {a[2:0], ~a[3]};
        m.neg_common = a[4];
        return m;
    endfunction

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Finishes a conversion, then sends a stray done that must be ignored.
    task automatic convert(input logic signed [24:0] v);
        for (int t = 0; t < 100 && converting !== 1'b1; t++) @(posedge sys_clk);
        repeat (20) @(posedge sys_clk);
        conv_value <= v;
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        conv_value <= ~v;
        @(posedge sys_clk);
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Cuts a hang short; a full run takes about 11000 cycles.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // Start pulses, counted at the falling edge so that each is seen once it has settled.
    always @(negedge sys_clk) begin
        if (!sys_rst && conv_start === 1'b1) begin
            n_start <= n_start + 1;
        end
    end

    // Every address loaded once, then four non-loading patterns and an abort.
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        chk("reset_addr", 33'h0, 33'(conv_addr));
        chk("reset_mux", {16'h0001, 16'h0002, 1'b0}, mux_sel);
        i_adc_host_model.idle_clocks(4);
        @(negedge sys_clk);
        chk("oe_idle", 33'h1, 33'(sdo_oe_n));
        cur = 5'h00;
        for (int i = 0; i < 36; i++) begin
            ctl = (i < 32) ? 3'h5 : bad[i - 32];
            ad = 5'(i);
            if (i == 0) begin
                i_adc_host_model.cs_set(1'b0);
                i_adc_host_model.wait_clk(8);
                @(negedge sys_clk);
                chk("eoc_busy", 33'h1, 33'(sdo));
            end
            convert(vals[i % 8]);
            @(negedge sys_clk);
            if (i == 0) chk("eoc_done", 33'h0, 33'(sdo));
            exp = exp_word(vals[i % 8], cur);
            if (i == 33) begin
                i_adc_host_model.frame(8'h00, 12, w);
                chk("abort_bits", 33'(exp[31:20]), 33'(w[11:0]));
                chk("abort_idle", 33'h0, 33'(converting));
                i_adc_host_model.wait_clk(8);
            end
            i_adc_host_model.frame({ctl, ad}, 32, w);
            chk("status", 33'(exp[31:29]), 33'(w[31:29]));
            chk("result", 33'(exp[28:6]), 33'(w[28:6]));
            chk("tag_par", 33'(exp[5:0]), 33'(w[5:0]));
            if (ctl == 3'h5) cur = ad;
            i_adc_host_model.wait_clk(8);
            @(negedge sys_clk);
            chk("next_addr", 33'(cur), 33'(conv_addr));
            chk("mux", exp_mux(cur), mux_sel);
            chk("restart", 33'h1, 33'(converting));
        end
        // One start from reset plus one per full read; the cut read starts nothing.
        chk("starts", 33'h25, 33'(n_start));
        stop_test();
    end
endmodule

`default_nettype wire
